// ### verilog/tmr8_pkg.sv
/*
 * Package for the 8-bit timer/counter unit: register offsets, field
 * positions, reset values and mode encodings.
 * Assumes a plain address/strobe register port, one system clock.
 */
package tmr8_pkg;
    localparam int ADDR_W = 3;
    // register offsets on the plain register port
    localparam logic [2:0] OFS_CTRL_A = 3'h0;
    localparam logic [2:0] OFS_CTRL_B = 3'h1;
    localparam logic [2:0] OFS_COUNT = 3'h2;
    localparam logic [2:0] OFS_CMP_A = 3'h3;
    localparam logic [2:0] OFS_CMP_B = 3'h4;
    localparam logic [2:0] OFS_MASK = 3'h5;
    localparam logic [2:0] OFS_FLAG = 3'h6;
    // field positions
    localparam int CTRL_A_WGM0 = 0;
    localparam int CTRL_A_WGM1 = 1;
    localparam int CTRL_B_CS_LO = 0;
    localparam int CTRL_B_WGM2 = 3;
    localparam int CTRL_B_FOC_B = 6;
    localparam int CTRL_B_FOC_A = 7;
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMP_A = 1;
    localparam int FLAG_CMP_B = 2;
    // limits
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // waveform modes
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_PC_MAX = 3'h1;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_PC_CMPA = 3'h5;
    localparam logic [2:0] WGM_FAST_CMPA = 3'h7;
    localparam logic [9:0] PRESC_RESET = 10'h000;
endpackage

// ### verilog/tmr8_unit.sv
/*
 * 8-bit timer/counter with two compare channels, overflow and compare
 * flags with masks, internal prescaler or external count input.
 * Assumes inputs synchronous to CLK except EXT_COUNT_IN, which is
 * synchronised here; registers reached over a plain strobe port.
 */
// Decided for this implementation: the address-and-strobe port and the register addresses.
// Behaviour
// RL1 - counter value 0x00 is the bottom indication
// RL2 - counter value 0xFF is the max indication
// RL3 - top is 0xFF or compare value A, chosen by mode
// RL4 - count value and both compare values are 8-bit registers
// RL5 - all flags in one flag register, each gated by a mask bit
// RL6 - 3-bit clock select chooses prescaler or external input
// RL7 - clock select picks source and edge, forming the timer clock
// RL8 - clock select zero stops the counter completely
// RL9 - software reads and writes the count value any time
// RL10 - software count write beats clear, increment and decrement
// RL11 - each timer clock clears, increments or decrements per mode
// RL12 - waveform mode: two bits in control A, top bit in control B
// RL13 - count steps by exactly one, up or down per direction
// RL14 - clear sets every counter bit to zero
// RL15 - internal top and bottom indications feed waveform logic
// RL16 - overflow flag set at mode-defined point, may interrupt
// RL17 - both compare values compared continuously, drive compare outputs
// RL18 - compare match sets that channel's compare flag
// RL19 - software clears the power-reduction bit before timer use
// RL20 - compare flag set on timer clock after counter equals compare
// RL21 - flag cleared by interrupt service or by writing one
// RL22 - mode 0 counts up, wraps, sets overflow when becoming zero
// RL23 - count write blocks compare matches for the next timer clock
// RL24 - external input synchronised, each selected edge one tick
`timescale 1ns/1ps
module tmr8_unit
    import tmr8_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // power reduction and interrupt acknowledge
    input wire logic POWER_REDUCTION,
    input wire logic ACK_OVF,
    input wire logic ACK_CMP_A,
    input wire logic ACK_CMP_B,
    // external count input
    input wire logic EXT_COUNT_IN,
    // outputs
    output logic COMPARE_OUTPUT_A,
    output logic COMPARE_OUTPUT_B,
    output logic IRQ_OVF,
    output logic IRQ_CMP_A,
    output logic IRQ_CMP_B
);
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] count_value;
        logic [7:0] compare_value_a;
        logic [7:0] compare_value_b;
        logic [2:0] mask;
        logic [2:0] flags;
        logic [9:0] presc;
        logic ext_s1;
        logic ext_s2;
        logic ext_prev;
        logic count_down;
        logic block;
        logic match_a_d;
        logic match_b_d;
        logic out_a;
        logic out_b;
        logic [7:0] rdata;
    } tmr8_state_t;

    tmr8_state_t st;
    tmr8_state_t next_st;

    function automatic logic tmr8_tick(input logic [2:0] cs, input logic [9:0] p,
                                       input logic ext_rise, input logic ext_fall);
        case (cs)
            CS_DIV1: tmr8_tick = 1'b1;
            CS_DIV8: tmr8_tick = (p[2:0] == 3'h7);
            CS_DIV64: tmr8_tick = (p[5:0] == 6'h3F);
            CS_DIV256: tmr8_tick = (p[7:0] == 8'hFF);
            CS_DIV1024: tmr8_tick = (p == 10'h3FF);
            CS_EXT_FALL: tmr8_tick = ext_fall;
            CS_EXT_RISE: tmr8_tick = ext_rise;
            default: tmr8_tick = 1'b0;
        endcase
    endfunction

    logic [2:0] wgm;
    logic [2:0] cs;
    logic [7:0] top;
    logic at_top;
    logic at_bottom;
    logic tick;
    logic match_a;
    logic match_b;
    logic pc_mode;
    logic fast_mode;
    logic count_wr;
    logic ext_rise;
    logic ext_fall;

    always_comb begin
        wgm = {st.ctrl_b[CTRL_B_WGM2], st.ctrl_a[CTRL_A_WGM1], st.ctrl_a[CTRL_A_WGM0]}; // [RL12]
        cs = st.ctrl_b[CTRL_B_CS_LO +: 3]; // [RL6]
        top = (wgm == WGM_CTC || wgm == WGM_PC_CMPA || wgm == WGM_FAST_CMPA) ? st.compare_value_a : CNT_MAX; // [RL3]
        at_top = (st.count_value == top); // [RL15] [RL2]
        at_bottom = (st.count_value == CNT_BOTTOM); // [RL1] [RL15]
        pc_mode = (wgm == WGM_PC_MAX || wgm == WGM_PC_CMPA);
        fast_mode = (wgm == WGM_FAST_MAX || wgm == WGM_FAST_CMPA);
        ext_rise = st.ext_s2 & ~st.ext_prev; // [RL24]
        ext_fall = ~st.ext_s2 & st.ext_prev; // [RL24]
        // power reduction stops the timer clock and clears the prescaler; register writes, acks and force strobes still act
        tick = ~POWER_REDUCTION & tmr8_tick(cs, st.presc, ext_rise, ext_fall); // [RL7] [RL8] [RL19]
        match_a = (st.count_value == st.compare_value_a); // [RL17]
        match_b = (st.count_value == st.compare_value_b); // [RL17]
        count_wr = WR && ADDR == OFS_COUNT;
    end

    always_comb begin
        next_st = st;
        next_st.ext_s1 = EXT_COUNT_IN;
        next_st.ext_s2 = st.ext_s1;
        next_st.ext_prev = st.ext_s2;
        next_st.presc = (cs == CS_STOP || POWER_REDUCTION) ? PRESC_RESET : st.presc + 10'h001;
        // clears first so a hardware set in the same cycle wins
        next_st.flags = st.flags & ~{ACK_CMP_B, ACK_CMP_A, ACK_OVF}; // [RL21]
        if (WR && ADDR == OFS_FLAG) begin
            next_st.flags = next_st.flags & ~WDATA[2:0]; // [RL21]
        end
        if (tick) begin
            next_st.block = 1'b0;
            // match seen this tick lands in the flag on the next tick
            next_st.match_a_d = match_a & ~st.block; // [RL23]
            next_st.match_b_d = match_b & ~st.block; // [RL23]
            if (st.match_a_d) begin
                next_st.flags[FLAG_CMP_A] = 1'b1; // [RL18] [RL20]
            end
            if (st.match_b_d) begin
                next_st.flags[FLAG_CMP_B] = 1'b1; // [RL18] [RL20]
            end
            if (pc_mode) begin
                if (at_top) begin
                    next_st.count_down = 1'b1;
                end else if (at_bottom) begin
                    next_st.count_down = 1'b0;
                end
                if (at_bottom) begin
                    next_st.flags[FLAG_OVF] = 1'b1; // [RL16]
                end
                next_st.count_value = (at_top && !at_bottom) || (st.count_down && !at_bottom)
                    ? st.count_value - 8'h01 : st.count_value + 8'h01; // [RL13] [RL11]
            end else if (at_top && wgm != WGM_NORMAL) begin
                next_st.count_down = 1'b0;
                next_st.count_value = RESET_BYTE; // [RL14] [RL11]
                if (fast_mode) begin
                    next_st.flags[FLAG_OVF] = 1'b1; // [RL16]
                end
            end else begin
                next_st.count_down = 1'b0;
                next_st.count_value = st.count_value + 8'h01; // [RL13] [RL22]
                if (st.count_value == CNT_MAX) begin
                    next_st.flags[FLAG_OVF] = 1'b1; // [RL22] [RL16]
                end
            end
            if (match_a & ~st.block) begin
                next_st.out_a = ~st.out_a; // [RL17]
            end
            if (match_b & ~st.block) begin
                next_st.out_b = ~st.out_b; // [RL17]
            end
        end
        if (WR) begin
            case (ADDR)
                OFS_CTRL_A: next_st.ctrl_a = WDATA;
                OFS_CTRL_B: begin
                    next_st.ctrl_b = WDATA & 8'h0F;
                    // force strobes toggle outputs without touching flags
                    if (WDATA[CTRL_B_FOC_A]) begin
                        next_st.out_a = ~st.out_a;
                    end
                    if (WDATA[CTRL_B_FOC_B]) begin
                        next_st.out_b = ~st.out_b;
                    end
                end
                OFS_COUNT: next_st.count_value = WDATA; // [RL9] [RL10]
                OFS_CMP_A: next_st.compare_value_a = WDATA; // [RL4]
                OFS_CMP_B: next_st.compare_value_b = WDATA; // [RL4]
                OFS_MASK: next_st.mask = WDATA[2:0]; // [RL5]
                default: next_st.ctrl_a = st.ctrl_a;
            endcase
        end
        if (count_wr) begin
            next_st.block = 1'b1; // [RL23]
            next_st.match_a_d = 1'b0;
            next_st.match_b_d = 1'b0;
        end
        next_st.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                OFS_CTRL_A: next_st.rdata = st.ctrl_a;
                OFS_CTRL_B: next_st.rdata = st.ctrl_b;
                OFS_COUNT: next_st.rdata = st.count_value; // [RL9]
                OFS_CMP_A: next_st.rdata = st.compare_value_a;
                OFS_CMP_B: next_st.rdata = st.compare_value_b;
                OFS_MASK: next_st.rdata = {5'h00, st.mask};
                OFS_FLAG: next_st.rdata = {5'h00, st.flags}; // [RL5]
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign RDATA = st.rdata;
    assign COMPARE_OUTPUT_A = st.out_a;
    assign COMPARE_OUTPUT_B = st.out_b;
    assign IRQ_OVF = st.flags[FLAG_OVF] & st.mask[FLAG_OVF]; // [RL5] [RL16]
    assign IRQ_CMP_A = st.flags[FLAG_CMP_A] & st.mask[FLAG_CMP_A]; // [RL5] [RL18]
    assign IRQ_CMP_B = st.flags[FLAG_CMP_B] & st.mask[FLAG_CMP_B]; // [RL5] [RL18]
endmodule

// ### verif/tmr8_properties.sv
/* port checker for tmr8_unit
   sees only the top ports; bound at the foot */
`timescale 1ns/1ps
module tmr8_properties
    import tmr8_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // control
    input wire logic POWER_REDUCTION,
    input wire logic ACK_OVF,
    // outputs
    input wire logic COMPARE_OUTPUT_A,
    input wire logic IRQ_OVF,
    input wire logic IRQ_CMP_A,
    input wire logic IRQ_CMP_B
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    idle_rdata_a: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data not zero");
    unmapped_read_a: assert property (RD && ADDR == 3'h7 |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    // power held so no tick can move the count between write and read
    count_readback_a: assert property (WR && ADDR == OFS_COUNT && POWER_REDUCTION ##1 !WR && POWER_REDUCTION
        ##1 RD && ADDR == OFS_COUNT && POWER_REDUCTION |=> RDATA == $past(WDATA, 3))
        else $error("count readback wrong");
    mask_off_a: assert property (WR && ADDR == OFS_MASK && WDATA[2:0] == 3'h0
        |=> !IRQ_OVF && !IRQ_CMP_A && !IRQ_CMP_B) else $error("masked irq high");
    ack_clear_a: assert property (ACK_OVF && POWER_REDUCTION |=> !IRQ_OVF)
        else $error("ack left overflow irq");
    w1c_clear_a: assert property (WR && ADDR == OFS_FLAG && WDATA[FLAG_CMP_A] && POWER_REDUCTION
        |=> !IRQ_CMP_A) else $error("write one left compare irq");
    force_toggle_a: assert property (WR && ADDR == OFS_CTRL_B && WDATA[CTRL_B_FOC_A] && POWER_REDUCTION
        |=> COMPARE_OUTPUT_A != $past(COMPARE_OUTPUT_A)) else $error("force did not toggle");
    pr_hold_a: assert property (POWER_REDUCTION && !WR |=> $stable(COMPARE_OUTPUT_A))
        else $error("output moved while powered down");
    pr_no_ovf_a: assert property (POWER_REDUCTION && !WR |=> !$rose(IRQ_OVF))
        else $error("overflow while powered down");
endmodule
bind tmr8_unit tmr8_properties u_props (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .POWER_REDUCTION(POWER_REDUCTION), .ACK_OVF(ACK_OVF), .COMPARE_OUTPUT_A(COMPARE_OUTPUT_A),
    .IRQ_OVF(IRQ_OVF), .IRQ_CMP_A(IRQ_CMP_A), .IRQ_CMP_B(IRQ_CMP_B));

// ### verif/tmr8_ext_src.sv
/* edge source on the external count pin
   driven after rising CLK edges, idles low */
`timescale 1ns/1ps
module tmr8_ext_src (
    // clock
    input wire logic CLK,
    // count pin
    output logic PIN
);
    initial PIN = 1'b0;
    // high level held 3..6 cycles, low level 4..7 between pulses, past the input synchroniser
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge CLK);
            PIN <= 1'b1;
            repeat ($urandom_range(6, 3)) @(posedge CLK);
            PIN <= 1'b0;
            repeat ($urandom_range(6, 3)) @(posedge CLK);
        end
    endtask
endmodule

// ### verif/tb_timer8_counter_unit.sv
/* self-checking bench for tmr8_unit
   bench drives the register port; tmr8_ext_src drives the count pin */
`timescale 1ns/1ps
module tb_timer8_counter_unit;
    import tmr8_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pr = 1'b1;
    logic ack_o = 1'b0, ack_a = 1'b0, ack_b = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, g;
    logic ext, oa, ob, io, ia, ib;
    int n_errors = 0, check_count = 0, cyc = 0;
    int dv[5] = '{1, 8, 64, 256, 1024};
    tmr8_unit u_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .POWER_REDUCTION(pr), .ACK_OVF(ack_o), .ACK_CMP_A(ack_a), .ACK_CMP_B(ack_b), .EXT_COUNT_IN(ext),
        .COMPARE_OUTPUT_A(oa), .COMPARE_OUTPUT_B(ob), .IRQ_OVF(io), .IRQ_CMP_A(ia), .IRQ_CMP_B(ib));
    tmr8_ext_src u_ext (.CLK(clk), .PIN(ext));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        int c, a, b, n, p, fo, fa, fb, fl, blk;
        int ta = 1, tb = 1;
        void'($urandom(26));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            reg_rd(3'(i), g);
            chk("reset read", 8'h00, g);
        end
        c = $urandom_range(255);
        reg_wr(OFS_MASK, 8'h00);
        reg_wr(OFS_COUNT, 8'(c));
        reg_rd(OFS_COUNT, g);
        chk("count readback", 8'(c), g);
        reg_wr(OFS_CTRL_B, 8'hC0);
        #1 chk("forced outputs", 8'h03, {6'h0, ob, oa});
        pr <= 1'b0;
        repeat (20) @(posedge clk);
        reg_rd(OFS_COUNT, g);
        chk("stopped count", 8'(c), g);
        // start and stop latency leave one or two ticks of slack
        for (int s = 1; s < 6; s++) begin
            reg_wr(OFS_COUNT, 8'h00);
            reg_wr(OFS_CTRL_B, 8'(s));
            repeat (dv[s - 1] * 10) @(posedge clk);
            reg_wr(OFS_CTRL_B, 8'h00);
            reg_rd(OFS_COUNT, g);
            chk("prescaled count", 8'h01, 8'(g >= 9 && g <= 13));
        end
        // about 39 ticks: an even number of toggles on both outputs
        reg_wr(OFS_CTRL_A, 8'(WGM_CTC));
        reg_wr(OFS_CMP_A, 8'h05);
        reg_wr(OFS_COUNT, 8'h00);
        reg_wr(OFS_CTRL_B, 8'(CS_DIV1));
        repeat (37) @(posedge clk);
        reg_wr(OFS_CTRL_B, 8'h00);
        reg_rd(OFS_COUNT, g);
        chk("ctc wrap", 8'h01, 8'(g <= 5));
        reg_wr(OFS_MASK, 8'h07);
        for (int i = 0; i < 12; i++) begin
            c = $urandom_range(255, 236);
            a = (c + ((i % 2) ? 0 : $urandom_range(6))) % 256;
            b = (c + $urandom_range(12)) % 256;
            n = $urandom_range(24, 1);
            p = (i % 4 == 3);
            pr <= p[0];
            reg_wr(OFS_FLAG, 8'h07);
            reg_wr(OFS_CTRL_A, 8'h00);
            reg_wr(OFS_CMP_A, 8'(a));
            reg_wr(OFS_CMP_B, 8'(b));
            reg_wr(OFS_COUNT, 8'(c));
            reg_wr(OFS_CTRL_B, (i % 2) ? 8'(CS_EXT_FALL) : 8'(CS_EXT_RISE));
            fo = 0;
            fa = 0;
            fb = 0;
            blk = 1;
            for (int k = 0; k < (p ? 0 : n); k++) begin
                // a match on the last tick reaches the flag only on a later tick
                fa |= (c == a && !blk && k < n - 1);
                ta ^= (c == a && !blk);
                fb |= (c == b && !blk && k < n - 1);
                tb ^= (c == b && !blk);
                c = (c + 1) % 256;
                fo |= (c == 0);
                blk = 0;
            end
            u_ext.pulses(n);
            repeat (5) @(posedge clk);
            reg_rd(OFS_COUNT, g);
            chk("count", 8'(c), g);
            fl = fo + 2 * fa + 4 * fb;
            reg_rd(OFS_FLAG, g);
            chk("flags", 8'(fl), g);
            chk("irq lines", 8'(fl), {5'h0, ib, ia, io});
            chk("compare outputs", 8'(ta + 2 * tb), {6'h0, ob, oa});
            a = $urandom_range(7);
            {ack_b, ack_a, ack_o} <= 3'(a);
            @(posedge clk);
            {ack_b, ack_a, ack_o} <= 3'h0;
            #1 chk("irq after ack", 8'(fl & ~a), {5'h0, ib, ia, io});
        end
        tally_and_finish();
    end
endmodule
